// File: vpg_pkg.sv
/*
  vpg_pkg: register map, field positions, reset values and pin
  group layout of the video port pin-control block.
  assumes 32-bit Avalon-MM word addressing by byte address.
*/
package vpg_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_FUNC = 4'h0;
  localparam logic [3:0] OFS_DIR = 4'h4;
  localparam logic [3:0] OFS_LEVEL = 4'h8;
  localparam logic [3:0] OFS_GPIO_OUT = 4'hc;
  localparam logic [3:0] OFS_MODE = 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0;
  // bit positions in the two select registers; only the ctl bits and bit 0 sit in both
  localparam int B_CTL3 = 22;
  localparam int B_CTL2 = 21;
  localparam int B_CTL1 = 20;
  localparam int B_UPPER = 10;
  localparam int B_LOWER = 0;
  localparam int B_DIR_TOP = 16;
  localparam int B_DIR_UMID = 12;
  localparam int B_DIR_LMID = 8;
  localparam int B_DIR_LOW = 4;
  localparam int B_DIR_BOT = 0;
  localparam logic [31:0] FUNC_MASK = 32'h0070_0401;
  localparam logic [31:0] DIR_MASK = 32'h0071_1111;
  // level readback covers ctl pins and data pins 19..12, 9..2
  localparam logic [31:0] LEVEL_MASK = 32'h007f_f3fc;
  localparam logic [31:0] FUNC_RST = 32'h0000_0000;
  localparam logic [31:0] DIR_RST = 32'h0000_0000;
  localparam logic [31:0] OUT_RST = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_RDATA = 32'h0000_0000;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } vpg_bus_req_s;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
    logic [1:0] response;
  } vpg_bus_rsp_s;

  // one bit per pin: [22:20] ctl3..ctl1, [19:2] data (11:10 unused)
  typedef struct packed {
    logic [22:0] o;
    logic [22:0] oe;
  } vpg_pin_drive_s;
endpackage : vpg_pkg

// File: vpg_pin_control.sv
/*
  vpg_pin_control: pin function and direction selection for the video
  port pins, with level readback and gpio output data, on Avalon-MM.
  assumes pins arrive already synchronous to clk, chip-level mux and
  port-enable status come in as levels from elsewhere in the chip.
*/
`timescale 1ns/10ps
module vpg_pin_control
  import vpg_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire vpg_bus_req_s bus_req,
  output vpg_bus_rsp_s bus_rsp,
  input wire logic [22:0] pin_in,
  input wire logic [22:0] video_out,
  input wire logic [22:0] video_oe,
  input wire logic [22:0] pin_muxed_away,
  input wire logic port_enabled,
  input wire logic narrow_capture_mode,
  output vpg_pin_drive_s pin_drive,
  output logic [22:0] pin_is_gpio
);

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_ANSWER = 2'b01
  } vpg_bus_state_e;

  vpg_bus_state_e state_q;
  logic [31:0] func_q;
  logic [31:0] dir_q;
  logic [31:0] out_q;
  logic [22:0] level_q;
  logic [31:0] rdata_q;
  logic [1:0] resp_q;
  logic [31:0] bemask;
  logic hit_func;
  logic hit_dir;
  logic hit_level;
  logic hit_out;
  logic mapped;
  logic take;
  logic ack;
  logic [22:0] gpio_sel;
  logic [22:0] dir_pin;

  assign hit_func = bus_req.address == OFS_FUNC;
  assign hit_dir = bus_req.address == OFS_DIR;
  assign hit_level = bus_req.address == OFS_LEVEL;
  assign hit_out = bus_req.address == OFS_GPIO_OUT;
  assign mapped = hit_func | hit_dir | hit_level | hit_out;
  // one wait cycle per access, answer registered in the next
  assign take = clk_en && state_q == ST_IDLE && (bus_req.read || bus_req.write);
  // writes land on the answer edge, the only edge the master counts
  assign ack = clk_en && state_q == ST_ANSWER;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      bemask[i*8 +: 8] = {8{bus_req.byteenable[i]}};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_q <= ST_IDLE;
    end
    else if (clk_en)
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (take)
          begin
            state_q <= ST_ANSWER;
          end
        end
        ST_ANSWER:
        begin
          state_q <= ST_IDLE;
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // masks keep reserved positions at zero on every write
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      func_q <= FUNC_RST;
      dir_q <= DIR_RST;
      out_q <= OUT_RST;
    end
    else if (ack && bus_req.write)
    begin
      if (hit_func)
      begin
        func_q <= ((func_q & ~bemask) | (bus_req.writedata & bemask)) & FUNC_MASK;
      end
      if (hit_dir)
      begin
        dir_q <= ((dir_q & ~bemask) | (bus_req.writedata & bemask)) & DIR_MASK;
      end
      if (hit_out)
      begin
        out_q <= ((out_q & ~bemask) | (bus_req.writedata & bemask)) & LEVEL_MASK;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      level_q <= '0;
    end
    else if (clk_en)
    begin
      level_q <= pin_in & LEVEL_MASK[22:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rdata_q <= '0;
      resp_q <= RESP_OK;
    end
    else if (take)
    begin
      resp_q <= mapped ? RESP_OK : RESP_DECERR;
      if (!bus_req.read)
      begin
        rdata_q <= '0;
      end
      else if (hit_func)
      begin
        rdata_q <= func_q;
      end
      else if (hit_dir)
      begin
        rdata_q <= dir_q;
      end
      else if (hit_level)
      begin
        rdata_q <= {9'h000, level_q};
      end
      else if (hit_out)
      begin
        rdata_q <= out_q;
      end
      else
      begin
        rdata_q <= UNMAPPED_RDATA;
      end
    end
  end

  assign bus_rsp.readdata = rdata_q;
  assign bus_rsp.response = resp_q;
  assign bus_rsp.waitrequest = !(state_q == ST_ANSWER && clk_en);

  // gpio selection per pin; data groups switch whole, ctl pins one by one
  always_comb
  begin
    gpio_sel = '0;
    gpio_sel[22] = func_q[B_CTL3];
    gpio_sel[21] = func_q[B_CTL2];
    gpio_sel[20] = func_q[B_CTL1];
    gpio_sel[19:12] = {8{func_q[B_UPPER]}};
    gpio_sel[9:2] = {8{func_q[B_LOWER]}};
    dir_pin = '0;
    dir_pin[22] = dir_q[B_CTL3];
    dir_pin[21] = dir_q[B_CTL2];
    dir_pin[20] = dir_q[B_CTL1];
    dir_pin[19:16] = {4{dir_q[B_DIR_TOP]}};
    dir_pin[15:12] = {4{dir_q[B_DIR_UMID]}};
    dir_pin[9:8] = {2{dir_q[B_DIR_LMID]}};
    dir_pin[7:4] = {4{dir_q[B_DIR_LOW]}};
    dir_pin[3:2] = {2{dir_q[B_DIR_BOT]}};
  end

  // narrow capture and a disabled port only leave pins free; the
  // function bits still decide, so software owns the handover
  genvar p;
  generate
    for (p = 0; p < 23; p++)
    begin : g_pin
      logic gp;
      assign gp = gpio_sel[p] && !pin_muxed_away[p];
      assign pin_is_gpio[p] = gp;
      assign pin_drive.oe[p] = gp ? dir_pin[p] : video_oe[p];
      assign pin_drive.o[p] = gp ? out_q[p] : video_out[p];
    end
  endgenerate

  // assertions
  property p_reserved_zero;
    @(posedge clk) disable iff (!resetn)
    ((func_q & ~FUNC_MASK) == 32'h0) && ((dir_q & ~DIR_MASK) == 32'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_upper_group;
    @(posedge clk) disable iff (!resetn)
    pin_is_gpio[19] == (func_q[B_UPPER] && !pin_muxed_away[19]);
  endproperty
  a_upper_group: assert property (p_upper_group) else $error("upper half select wrong");

  property p_lower_group;
    @(posedge clk) disable iff (!resetn)
    pin_is_gpio[2] == (func_q[B_LOWER] && !pin_muxed_away[2]);
  endproperty
  a_lower_group: assert property (p_lower_group) else $error("lower half select wrong");

  property p_ctl3;
    @(posedge clk) disable iff (!resetn)
    pin_is_gpio[22] == (func_q[B_CTL3] && !pin_muxed_away[22]);
  endproperty
  a_ctl3: assert property (p_ctl3) else $error("ctl3 select wrong");

  property p_muxed_away;
    @(posedge clk) disable iff (!resetn)
    (pin_muxed_away & pin_is_gpio) == 23'h0;
  endproperty
  a_muxed_away: assert property (p_muxed_away) else $error("muxed pin taken as gpio");

  property p_video_passthru;
    @(posedge clk) disable iff (!resetn)
    !pin_is_gpio[20] |-> pin_drive.oe[20] == video_oe[20] && pin_drive.o[20] == video_out[20];
  endproperty
  a_video_passthru: assert property (p_video_passthru) else $error("direction leaked to video pin");

  property p_dir_top;
    @(posedge clk) disable iff (!resetn)
    pin_is_gpio[16] && pin_is_gpio[19] |-> pin_drive.oe[16] == dir_q[B_DIR_TOP] && pin_drive.oe[19] == dir_q[B_DIR_TOP];
  endproperty
  a_dir_top: assert property (p_dir_top) else $error("top data direction wrong");

  property p_gpio_data;
    @(posedge clk) disable iff (!resetn)
    pin_is_gpio[4] && dir_q[B_DIR_LOW] |-> pin_drive.oe[4] && pin_drive.o[4] == out_q[4];
  endproperty
  a_gpio_data: assert property (p_gpio_data) else $error("gpio output data wrong");

  sequence s_req;
    state_q == ST_IDLE && clk_en && bus_req.read && bus_req.address == OFS_LEVEL;
  endsequence
  property p_level_read;
    @(posedge clk) disable iff (!resetn)
    s_req |=> bus_rsp.readdata == {9'h000, $past(level_q)};
  endproperty
  a_level_read: assert property (p_level_read) else $error("level readback wrong");

  // bus handshake steps: take, then exactly one answer cycle
  sequence s_take;
    take;
  endsequence
  sequence s_answer;
    state_q == ST_ANSWER && bus_rsp.waitrequest == !clk_en;
  endsequence
  property p_answer_next;
    @(posedge clk) disable iff (!resetn)
    s_take |=> s_answer;
  endproperty
  a_answer_next: assert property (p_answer_next) else $error("answer not in next cycle");

  property p_no_early_write;
    @(posedge clk) disable iff (!resetn)
    s_take |=> $stable(func_q) && $stable(dir_q) && $stable(out_q);
  endproperty
  a_no_early_write: assert property (p_no_early_write) else $error("register written before answer");

  sequence s_func_write;
    ack && bus_req.write && hit_func && bus_req.byteenable == 4'hf;
  endsequence
  property p_write_lands;
    @(posedge clk) disable iff (!resetn)
    s_func_write |=> func_q == ($past(bus_req.writedata) & FUNC_MASK);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("function write lost or reserved kept");

  property p_unmapped;
    @(posedge clk) disable iff (!resetn)
    take && !mapped |=> bus_rsp.response == RESP_DECERR && bus_rsp.readdata == UNMAPPED_RDATA;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access answered wrong");

  property p_freeze;
    @(posedge clk) disable iff (!resetn)
    !clk_en |=> $stable(func_q) && $stable(dir_q) && $stable(out_q) && $stable(level_q) && $stable(state_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

  property p_narrow_upper;
    @(posedge clk) disable iff (!resetn)
    narrow_capture_mode && func_q[B_UPPER] |-> pin_is_gpio[19:12] == ~pin_muxed_away[19:12];
  endproperty
  a_narrow_upper: assert property (p_narrow_upper) else $error("upper half blocked in narrow mode");

  property p_port_off;
    @(posedge clk) disable iff (!resetn)
    !port_enabled && ((func_q & FUNC_MASK) == FUNC_MASK) |-> pin_is_gpio == (LEVEL_MASK[22:0] & ~pin_muxed_away);
  endproperty
  a_port_off: assert property (p_port_off) else $error("pin blocked with port disabled");

  property p_dir_ctl;
    @(posedge clk) disable iff (!resetn)
    pin_is_gpio[21] |-> pin_drive.oe[21] == dir_q[B_CTL2];
  endproperty
  a_dir_ctl: assert property (p_dir_ctl) else $error("ctl2 direction wrong");

  property p_dir_lmid;
    @(posedge clk) disable iff (!resetn)
    pin_is_gpio[8] && pin_is_gpio[9] |-> pin_drive.oe[8] == dir_q[B_DIR_LMID] && pin_drive.oe[9] == dir_q[B_DIR_LMID];
  endproperty
  a_dir_lmid: assert property (p_dir_lmid) else $error("data 9..8 direction wrong");

endmodule : vpg_pin_control

// File: vpg_board.sv
/*
  vpg_board: external board model for the video port pins.
  assumes the port's pin drive struct; the board drives every pin
  that the port leaves undriven, with a level chosen by the bench.
*/
`timescale 1ns/10ps
module vpg_board
  import vpg_pkg::*;
(
  input wire vpg_pin_drive_s pin_drive,
  input wire logic [22:0] ext_level,
  output logic [22:0] pin_in
);
  // board yields wherever the port drives, so no contention
  assign pin_in = (pin_drive.oe & pin_drive.o) | (~pin_drive.oe & ext_level);
endmodule : vpg_board

// File: video_port_gpio_pin_control_test.sv
/*
  video_port_gpio_pin_control_test: self-checking bench for the pin
  control block, random setups plus byte-lane and unmapped corners.
  assumes vpg_board as the far side; clk_en is held low once mid-run.
*/
`timescale 1ns/10ps
module video_port_gpio_pin_control_test;
  import vpg_pkg::*;
  logic clk = 0;
  logic resetn = 0;
  logic pen = 1;
  logic nar = 0;
  logic cen = 1;
  vpg_bus_req_s req = '0;
  vpg_bus_rsp_s rsp;
  vpg_pin_drive_s drv;
  logic [22:0] pin_in, gp, g, e, eo, ev;
  logic [22:0] vo = '0;
  logic [22:0] voe = '0;
  logic [22:0] mux = '0;
  logic [22:0] ext = '0;
  logic [31:0] rd, f, d, q;
  logic [1:0] rs;
  int n_fail = 0;
  int n_tests = 0;

  always #25 clk = ~clk;

  vpg_pin_control vpg_pin_control_i (.clk(clk), .resetn(resetn), .clk_en(cen), .bus_req(req), .bus_rsp(rsp),
    .pin_in(pin_in), .video_out(vo), .video_oe(voe), .pin_muxed_away(mux), .port_enabled(pen),
    .narrow_capture_mode(nar), .pin_drive(drv), .pin_is_gpio(gp));
  vpg_board vpg_board_i (.pin_drive(drv), .ext_level(ext), .pin_in(pin_in));

  function automatic logic [22:0] gsel(input logic [31:0] fv, input logic [22:0] mx);
    return {fv[22:20], {8{fv[10]}}, 2'b00, {8{fv[0]}}, 2'b00} & ~mx;
  endfunction : gsel

  function automatic logic [22:0] dsel(input logic [31:0] dv);
    return {dv[22:20], {4{dv[16]}}, {4{dv[12]}}, 2'b00, {2{dv[8]}}, {4{dv[4]}}, {2{dv[0]}}, 2'b00};
  endfunction : dsel

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one access; holds the request until waitrequest is seen low
  task automatic acc(input logic [3:0] a, input logic w, input logic [31:0] dt, input logic [3:0] be);
    int n;
    @(posedge clk);
    req <= '{address: a, read: !w, write: w, writedata: dt, byteenable: be};
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (rsp.waitrequest === 1'b0)
        break;
    end
    rd = rsp.readdata;
    rs = rsp.response;
    req.read <= 1'b0;
    req.write <= 1'b0;
    if (n == 20)
    begin
      n_fail++;
      close_out();
    end
  endtask : acc

  initial
  begin
    void'($urandom(45932));
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    acc(OFS_FUNC, 0, '0, '0);
    chk("func reset", FUNC_RST, rd);
    acc(OFS_DIR, 0, '0, '0);
    chk("dir reset", DIR_RST, rd);
    chk("gpio reset", '0, gp);
    $display("test reset done");
    for (int i = 0; i < 40; i++)
    begin
      f = (i == 1) ? '1 : $urandom;
      d = (i == 1) ? '1 : $urandom;
      q = $urandom;
      // software keeps traffic off gpio pins: video drive is only a stand-in
      mux <= (i % 4 == 0) ? 23'($urandom) : '0;
      vo <= 23'($urandom);
      voe <= 23'($urandom);
      ext <= 23'($urandom);
      pen <= (i == 1) ? 1'b0 : 1'($urandom);
      nar <= (i == 1) ? 1'b1 : 1'($urandom);
      acc(OFS_FUNC, 1, f, 4'hf);
      acc(OFS_DIR, 1, d, 4'hf);
      acc(OFS_GPIO_OUT, 1, q, 4'hf);
      acc(OFS_FUNC, 0, '0, '0);
      chk("func", f & FUNC_MASK, rd);
      chk("func resp", RESP_OK, rs);
      acc(OFS_DIR, 0, '0, '0);
      chk("dir", d & DIR_MASK, rd);
      g = gsel(f, mux);
      e = dsel(d);
      eo = (g & e) | (~g & voe);
      ev = (g & q[22:0]) | (~g & vo);
      chk("gpio", g, gp);
      chk("oe", eo, drv.oe);
      chk("o", ev, drv.o);
      acc(OFS_LEVEL, 1, '1, 4'hf);
      acc(OFS_LEVEL, 0, '0, '0);
      chk("level", ((eo & ev) | (~eo & ext)) & LEVEL_MASK, rd);
    end
    $display("test random setups done");
    acc(OFS_FUNC, 1, '0, 4'hf);
    acc(OFS_FUNC, 1, '1, 4'h4);
    acc(OFS_FUNC, 0, '0, '0);
    chk("func lane2", 32'h0070_0000, rd);
    acc(OFS_FUNC, 1, '1, 4'h2);
    acc(OFS_FUNC, 0, '0, '0);
    chk("func lane1", 32'h0070_0400, rd);
    acc(4'h2, 1, '1, 4'hf);
    acc(4'h2, 0, '0, '0);
    chk("unmapped resp", RESP_DECERR, rs);
    chk("unmapped data", UNMAPPED_RDATA, rd);
    acc(OFS_FUNC, 0, '0, '0);
    chk("func kept", 32'h0070_0400, rd);
    $display("test lanes and unmapped done");
    @(posedge clk);
    cen <= 1'b0;
    fork
      acc(OFS_DIR, 1, 32'h0000_1111, 4'hf);
      begin
        repeat (3) @(posedge clk);
        chk("wait held", 32'h1, rsp.waitrequest);
        repeat (2) @(posedge clk);
        cen <= 1'b1;
      end
    join
    acc(OFS_DIR, 0, '0, '0);
    chk("dir after freeze", 32'h0000_1111, rd);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    acc(OFS_FUNC, 0, '0, '0);
    chk("func rereset", FUNC_RST, rd);
    acc(OFS_DIR, 0, '0, '0);
    chk("dir rereset", DIR_RST, rd);
    chk("gpio rereset", '0, gp);
    $display("test freeze and reset done");
    close_out();
  end
endmodule : video_port_gpio_pin_control_test
